// [rtl/dtm_pkg.sv]
// package of the dual timer block: register map, field layouts, modes, timing counts
// assumes a byte-wide register port with 12-bit addresses
package dtm_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 8;
  localparam logic [11:0] OFS_CTRL     = 12'h410;
  localparam logic [11:0] OFS_STATUS   = 12'h411;
  localparam logic [11:0] OFS_PRESCALE = 12'h412;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h420;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h421;
  localparam logic [11:0] OFS_TL0      = 12'h450;
  localparam logic [11:0] OFS_TH0      = 12'h451;
  localparam logic [11:0] OFS_TL1      = 12'h452;
  localparam logic [11:0] OFS_TH1      = 12'h453;
  localparam logic [11:0] OFS_RTL0     = 12'h454;
  localparam logic [11:0] OFS_RTH0     = 12'h455;
  localparam logic [11:0] OFS_RTL1     = 12'h456;
  localparam logic [11:0] OFS_RTH1     = 12'h457;
  localparam logic [11:0] OFS_MODE     = 12'h45c;

  // ****************************************************************
  // reset values and field positions
  // ****************************************************************
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [1:0] RST_PRESCALE = 2'h0;
  localparam logic [3:0] RST_IRQ      = 4'h0;
  localparam int         STAT_T0OE    = 0;
  localparam int         STAT_TIMER1_TOGGLE_OUTPUT_ENABLE    = 2;
  // interrupt request / status bit positions
  localparam int         IRQ_TF0      = 0;
  localparam int         IRQ_TF1      = 1;
  localparam int         IRQ_IE0      = 2;
  localparam int         IRQ_IE1      = 3;

  // ****************************************************************
  // timing: prescaler terminal counts (divide by 4, 16, 64)
  // ****************************************************************
  localparam logic [5:0] PRESC_LAST_4  = 6'h03;
  localparam logic [5:0] PRESC_LAST_16 = 6'h0f;
  localparam logic [5:0] PRESC_LAST_64 = 6'h3f;

  typedef enum logic [1:0] {
    DTM_PRESC_4  = 2'b00,
    DTM_PRESC_16 = 2'b01,
    DTM_PRESC_64 = 2'b10
  } dtm_presc_t;

  typedef enum logic [1:0] {
    DTM_MODE_16_RELOAD = 2'b00,
    DTM_MODE_16        = 2'b01,
    DTM_MODE_8_RELOAD  = 2'b10,
    DTM_MODE_SPLIT     = 2'b11
  } dtm_mode_t;

  typedef struct packed {
    logic      gate1;
    logic      ct1;
    dtm_mode_t mode1;
    logic      gate0;
    logic      ct0;
    dtm_mode_t mode0;
  } dtm_timer_mode_register_t;

  typedef struct packed {
    logic timer1_overflow_flag;
    logic timer1_run;
    logic timer0_overflow_flag;
    logic timer0_run;
    logic ext_irq1_edge_flag;
    logic ext_irq1_trigger_type;
    logic ext_irq0_edge_flag;
    logic ext_irq0_trigger_type;
  } dtm_timer_control_flags_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } dtm_bus_req_t;

endpackage

// [rtl/dtm_pin_sync.sv]
// two-flop synchronisers for outside pins, with falling-edge pulses
// assumes pins are asynchronous to sys_clk
`timescale 1ns/1ps
module dtm_pin_sync #(
  parameter int W = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // pins idle high, so reset to ones to avoid a false edge
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_reg <= '1;
      sync_reg <= '1;
      prev_reg <= '1;
    end
    else
    begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign fall  = prev_reg & ~sync_reg;

endmodule

// [rtl/dtm_byte_counter.sv]
// one count byte: software write, then load, then increment
// assumes at most one load source per cycle chosen by the caller
`timescale 1ns/1ps
module dtm_byte_counter #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         inc,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         wr,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] count,
  output logic              wrap
);

  logic [W-1:0] count_reg;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      count_reg <= '0;
    else if (wr)
      count_reg <= wr_data;
    else if (load)
      count_reg <= load_val;
    else if (inc)
      count_reg <= W'(count_reg + 1'b1);
  end

  assign count = count_reg;
  assign wrap  = inc & (&count_reg);

endmodule

// [rtl/dtm_top.sv]
// dual timer block: timers 0 and 1 in modes 0..3, control/flag register, interrupts
// assumes a single-cycle register port and an interrupt controller acking vectored requests
//
// Functional notes
// - mode 1 is plain 16-bit count, no reload
// - mode 2 low byte overflow sets flag, reloads
// - mode 2 reload leaves high byte alone
// - mode 2 identical for both timers
// - mode 2 overflow every N*(256-reload) clocks
// - timer 1 in mode 3 holds count
// - timer 0 mode 3 low byte uses timer-0 controls
// - split high byte: internal clock, timer-1 run/flag
// - timer 1 stops in mode 3, still baud source with timer 0 in mode 3
// - timer 1 flag set unless its toggle enabled
// - timer 0 flag set unless its toggle enabled
// - overflow flag cleared on vector or software
// - edge flag set on edge, cleared when processed
// - type bit selects falling edge or low level
// - mode field encodes the four modes
// - gating needs run bit and high irq pin
// - select bit picks prescaled clock or pin
`timescale 1ns/1ps
module dtm_top (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire dtm_pkg::dtm_bus_req_t bus_req,
  output logic [7:0]                 rd_data,
  input  wire logic                  ext_irq0_pin,
  input  wire logic                  ext_irq1_pin,
  input  wire logic                  t0_count_pin,
  input  wire logic                  t1_count_pin,
  input  wire logic [3:0]            irq_ack,
  output logic [3:0]                 irq_req,
  output logic                       irq,
  output logic                       t1_baud_tick,
  output logic                       t0_toggle_out,
  output logic                       t1_toggle_out
);

  // ****************************************************************
  // registers and decode
  // ****************************************************************
  dtm_pkg::dtm_timer_control_flags_t timer_control_flags_reg;
  dtm_pkg::dtm_timer_mode_register_t timer_mode_register_reg;
  logic [7:0]         stat_reg;
  logic [1:0]         presc_sel_reg;
  logic [3:0]         irq_stat_reg;
  logic [3:0]         irq_mask_reg;
  logic [7:0]         rtl0_reg, rth0_reg, rtl1_reg, rth1_reg;
  logic [7:0]         rd_data_reg;
  logic [5:0]         presc_cnt_reg;
  logic               t1_baud_reg, t0_tog_reg, t1_tog_reg;
  logic wr_ctrl, wr_stat, wr_presc, wr_istat, wr_imask, wr_mode;
  logic wr_tl0, wr_th0, wr_tl1, wr_th1, wr_rtl0, wr_rth0, wr_rtl1, wr_rth1;
  logic [7:0] rd_mux;
  logic [7:0] tl0, th0, tl1, th1;
  always_comb
  begin
    {wr_ctrl, wr_stat, wr_presc, wr_istat, wr_imask, wr_mode} = '0;
    {wr_tl0, wr_th0, wr_tl1, wr_th1, wr_rtl0, wr_rth0, wr_rtl1, wr_rth1} = '0;
    rd_mux = 8'h00;
    if (bus_req.addr == dtm_pkg::OFS_CTRL)
    begin
      wr_ctrl = bus_req.wr;
      rd_mux  = timer_control_flags_reg;
    end
    else if (bus_req.addr == dtm_pkg::OFS_STATUS)
    begin
      wr_stat = bus_req.wr;
      rd_mux  = stat_reg;
    end
    else if (bus_req.addr == dtm_pkg::OFS_PRESCALE)
    begin
      wr_presc = bus_req.wr;
      rd_mux   = {6'h00, presc_sel_reg};
    end
    else if (bus_req.addr == dtm_pkg::OFS_IRQ_STAT)
    begin
      wr_istat = bus_req.wr;
      rd_mux   = {4'h0, irq_stat_reg};
    end
    else if (bus_req.addr == dtm_pkg::OFS_IRQ_MASK)
    begin
      wr_imask = bus_req.wr;
      rd_mux   = {4'h0, irq_mask_reg};
    end
    else if (bus_req.addr == dtm_pkg::OFS_MODE)
    begin
      wr_mode = bus_req.wr;
      rd_mux  = timer_mode_register_reg;
    end
    else if (bus_req.addr == dtm_pkg::OFS_TL0)
    begin
      wr_tl0 = bus_req.wr;
      rd_mux = tl0;
    end
    else if (bus_req.addr == dtm_pkg::OFS_TH0)
    begin
      wr_th0 = bus_req.wr;
      rd_mux = th0;
    end
    else if (bus_req.addr == dtm_pkg::OFS_TL1)
    begin
      wr_tl1 = bus_req.wr;
      rd_mux = tl1;
    end
    else if (bus_req.addr == dtm_pkg::OFS_TH1)
    begin
      wr_th1 = bus_req.wr;
      rd_mux = th1;
    end
    else if (bus_req.addr == dtm_pkg::OFS_RTL0)
    begin
      wr_rtl0 = bus_req.wr;
      rd_mux  = rtl0_reg;
    end
    else if (bus_req.addr == dtm_pkg::OFS_RTH0)
    begin
      wr_rth0 = bus_req.wr;
      rd_mux  = rth0_reg;
    end
    else if (bus_req.addr == dtm_pkg::OFS_RTL1)
    begin
      wr_rtl1 = bus_req.wr;
      rd_mux  = rtl1_reg;
    end
    else if (bus_req.addr == dtm_pkg::OFS_RTH1)
    begin
      wr_rth1 = bus_req.wr;
      rd_mux  = rth1_reg;
    end
  end
  // read data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rd_data_reg <= dtm_pkg::RST_BYTE;
    else
      rd_data_reg <= bus_req.rd ? rd_mux : 8'h00;
  end
  assign rd_data = rd_data_reg;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_mode_register_reg      <= dtm_pkg::RST_BYTE;
      stat_reg      <= dtm_pkg::RST_BYTE;
      presc_sel_reg <= dtm_pkg::RST_PRESCALE;
      irq_mask_reg  <= dtm_pkg::RST_IRQ;
      rtl0_reg      <= dtm_pkg::RST_BYTE;
      rth0_reg      <= dtm_pkg::RST_BYTE;
      rtl1_reg      <= dtm_pkg::RST_BYTE;
      rth1_reg      <= dtm_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_mode)  timer_mode_register_reg      <= bus_req.wdata;
      if (wr_stat)  stat_reg      <= bus_req.wdata;
      if (wr_presc) presc_sel_reg <= bus_req.wdata[1:0];
      if (wr_imask) irq_mask_reg  <= bus_req.wdata[3:0];
      if (wr_rtl0)  rtl0_reg      <= bus_req.wdata;
      if (wr_rth0)  rth0_reg      <= bus_req.wdata;
      if (wr_rtl1)  rtl1_reg      <= bus_req.wdata;
      if (wr_rth1)  rth1_reg      <= bus_req.wdata;
    end
  end

  // ****************************************************************
  // pins and prescaler
  // ****************************************************************
  logic [3:0] pin_lvl, pin_fall;
  logic       presc_tick;
  dtm_pin_sync #(.W(4)) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pin     ({t1_count_pin, t0_count_pin, ext_irq1_pin, ext_irq0_pin}),
    .level   (pin_lvl),
    .fall    (pin_fall)
  );
  function automatic logic [5:0] presc_last(input logic [1:0] sel);
    case (sel)
      dtm_pkg::DTM_PRESC_16: presc_last = dtm_pkg::PRESC_LAST_16;
      dtm_pkg::DTM_PRESC_64: presc_last = dtm_pkg::PRESC_LAST_64;
      default:               presc_last = dtm_pkg::PRESC_LAST_4;
    endcase
  endfunction
  assign presc_tick = (presc_cnt_reg >= presc_last(presc_sel_reg));
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      presc_cnt_reg <= 6'h00;
    else
      presc_cnt_reg <= presc_tick ? 6'h00 : 6'(presc_cnt_reg + 1'b1);
  end

  // ****************************************************************
  // counters
  // ****************************************************************
  dtm_pkg::dtm_mode_t mode0, mode1;
  logic split0, run0, run1, tl0_inc, th0_inc, tl1_inc, th1_inc;
  logic tl0_wrap, th0_wrap, tl1_wrap, th1_wrap;
  logic tl0_load, th0_load, tl1_load, th1_load;
  logic t0_ovf, t1_ovf, th0_split_ovf, tf0_set, tf1_set;
  assign mode0  = timer_mode_register_reg.mode0;
  assign mode1  = timer_mode_register_reg.mode1;
  assign split0 = (mode0 == dtm_pkg::DTM_MODE_SPLIT);
  // run bit, optionally gated by the irq pin level
  assign run0 = timer_control_flags_reg.timer0_run & (~timer_mode_register_reg.gate0 | pin_lvl[0]);
  // with timer 0 split its high byte owns the run bit; timer 1 runs unless in mode 3 or gated by a low irq pin
  assign run1 = (split0 | timer_control_flags_reg.timer1_run) & (~timer_mode_register_reg.gate1 | pin_lvl[1])
                & (mode1 != dtm_pkg::DTM_MODE_SPLIT);
  assign tl0_inc = run0 & (timer_mode_register_reg.ct0 ? pin_fall[2] : presc_tick);
  assign tl1_inc = run1 & (timer_mode_register_reg.ct1 ? pin_fall[3] : presc_tick);
  // split high byte: internal clock only, started by timer 1 run bit
  assign th0_inc = split0 ? (timer_control_flags_reg.timer1_run & presc_tick)
                 : (mode0 == dtm_pkg::DTM_MODE_8_RELOAD) ? 1'b0
                 : tl0_wrap;
  assign th1_inc = (mode1 == dtm_pkg::DTM_MODE_8_RELOAD) ? 1'b0 : tl1_wrap;
  assign tl0_load = (mode0 == dtm_pkg::DTM_MODE_8_RELOAD) ? tl0_wrap
                  : (mode0 == dtm_pkg::DTM_MODE_16_RELOAD) & th0_wrap;
  assign th0_load = (mode0 == dtm_pkg::DTM_MODE_16_RELOAD) & th0_wrap;
  assign tl1_load = (mode1 == dtm_pkg::DTM_MODE_8_RELOAD) ? tl1_wrap
                  : (mode1 == dtm_pkg::DTM_MODE_16_RELOAD) & th1_wrap;
  assign th1_load = (mode1 == dtm_pkg::DTM_MODE_16_RELOAD) & th1_wrap;
  assign t0_ovf = (mode0[1]) ? tl0_wrap : th0_wrap;
  assign t1_ovf = (mode1[1]) ? tl1_wrap : th1_wrap;
  assign th0_split_ovf = split0 & th0_wrap;
  dtm_byte_counter #(.W(8)) u_tl0 (.sys_clk(sys_clk), .rstn(rstn), .inc(tl0_inc),
    .load(tl0_load), .load_val(rtl0_reg), .wr(wr_tl0), .wr_data(bus_req.wdata),
    .count(tl0), .wrap(tl0_wrap));
  dtm_byte_counter #(.W(8)) u_th0 (.sys_clk(sys_clk), .rstn(rstn), .inc(th0_inc),
    .load(th0_load), .load_val(rth0_reg), .wr(wr_th0), .wr_data(bus_req.wdata),
    .count(th0), .wrap(th0_wrap));
  dtm_byte_counter #(.W(8)) u_tl1 (.sys_clk(sys_clk), .rstn(rstn), .inc(tl1_inc),
    .load(tl1_load), .load_val(rtl1_reg), .wr(wr_tl1), .wr_data(bus_req.wdata),
    .count(tl1), .wrap(tl1_wrap));
  dtm_byte_counter #(.W(8)) u_th1 (.sys_clk(sys_clk), .rstn(rstn), .inc(th1_inc),
    .load(th1_load), .load_val(rth1_reg), .wr(wr_th1), .wr_data(bus_req.wdata),
    .count(th1), .wrap(th1_wrap));
  // ****************************************************************
  // control/flag register and interrupts
  // ****************************************************************
  logic ie0_set, ie1_set;
  logic [3:0] events;
  assign tf0_set = t0_ovf & ~stat_reg[dtm_pkg::STAT_T0OE];
  assign tf1_set = (split0 ? th0_split_ovf : t1_ovf) & ~stat_reg[dtm_pkg::STAT_TIMER1_TOGGLE_OUTPUT_ENABLE];
  assign ie0_set = timer_control_flags_reg.ext_irq0_trigger_type & pin_fall[0];
  assign ie1_set = timer_control_flags_reg.ext_irq1_trigger_type & pin_fall[1];
  // hardware set wins over vector ack and software write
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      timer_control_flags_reg <= dtm_pkg::RST_BYTE;
    else
    begin
      if (wr_ctrl)
        timer_control_flags_reg <= bus_req.wdata;
      if (irq_ack[dtm_pkg::IRQ_TF0]) timer_control_flags_reg.timer0_overflow_flag <= 1'b0;
      if (irq_ack[dtm_pkg::IRQ_TF1]) timer_control_flags_reg.timer1_overflow_flag <= 1'b0;
      if (irq_ack[dtm_pkg::IRQ_IE0]) timer_control_flags_reg.ext_irq0_edge_flag   <= 1'b0;
      if (irq_ack[dtm_pkg::IRQ_IE1]) timer_control_flags_reg.ext_irq1_edge_flag   <= 1'b0;
      if (tf0_set) timer_control_flags_reg.timer0_overflow_flag <= 1'b1;
      if (tf1_set) timer_control_flags_reg.timer1_overflow_flag <= 1'b1;
      if (ie0_set) timer_control_flags_reg.ext_irq0_edge_flag   <= 1'b1;
      if (ie1_set) timer_control_flags_reg.ext_irq1_edge_flag   <= 1'b1;
    end
  end
  // low-level mode requests follow the synchronised pin level, two clocks behind the pin
  assign irq_req[dtm_pkg::IRQ_TF0] = timer_control_flags_reg.timer0_overflow_flag;
  assign irq_req[dtm_pkg::IRQ_TF1] = timer_control_flags_reg.timer1_overflow_flag;
  assign irq_req[dtm_pkg::IRQ_IE0] = timer_control_flags_reg.ext_irq0_trigger_type ?
                                     timer_control_flags_reg.ext_irq0_edge_flag : ~pin_lvl[0];
  assign irq_req[dtm_pkg::IRQ_IE1] = timer_control_flags_reg.ext_irq1_trigger_type ?
                                     timer_control_flags_reg.ext_irq1_edge_flag : ~pin_lvl[1];
  assign events = {pin_fall[1], pin_fall[0], tf1_set, tf0_set};
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      irq_stat_reg <= dtm_pkg::RST_IRQ;
    else
      irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? bus_req.wdata[3:0] : 4'h0)) | events;
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);
  // baud tick and toggle outputs
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      t1_baud_reg <= 1'b0;
      t0_tog_reg  <= 1'b0;
      t1_tog_reg  <= 1'b0;
    end
    else
    begin
      t1_baud_reg <= t1_ovf;
      if (t0_ovf & stat_reg[dtm_pkg::STAT_T0OE]) t0_tog_reg <= ~t0_tog_reg;
      if (t1_ovf & stat_reg[dtm_pkg::STAT_TIMER1_TOGGLE_OUTPUT_ENABLE]) t1_tog_reg <= ~t1_tog_reg;
    end
  end
  assign t1_baud_tick  = t1_baud_reg;
  assign t0_toggle_out = t0_tog_reg;
  assign t1_toggle_out = t1_tog_reg;
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  mode2_reload_a: assert property (mode0 == dtm_pkg::DTM_MODE_8_RELOAD && tl0_wrap && !wr_tl0
    |=> tl0 == $past(rtl0_reg) && (timer_control_flags_reg.timer0_overflow_flag || $past(stat_reg[0])))
    else $error("mode 2 reload wrong");
  mode2_high_a: assert property (mode1 == dtm_pkg::DTM_MODE_8_RELOAD && !wr_th1
    |=> th1 == $past(th1)) else $error("mode 2 high byte changed");
  mode1_roll_a: assert property (mode0 == dtm_pkg::DTM_MODE_16 && th0_wrap && !wr_tl0
    && !wr_th0 |=> tl0 == 8'h00 && th0 == 8'h00) else $error("mode 1 rollover wrong");
  t1_hold_a: assert property (mode1 == dtm_pkg::DTM_MODE_SPLIT && !wr_tl1 && !wr_th1
    |=> $stable(tl1) && $stable(th1)) else $error("timer 1 moved in mode 3");
  split_flag_a: assert property (split0 && th0_wrap && !stat_reg[2]
    |=> timer_control_flags_reg.timer1_overflow_flag) else $error("split high overflow lost");
  oe_block_a: assert property (stat_reg[0] && !timer_control_flags_reg.timer0_overflow_flag
    && !wr_ctrl |=> !timer_control_flags_reg.timer0_overflow_flag) else $error("flag set with toggle enabled");
  ack_clear_a: assert property (irq_ack[0] && !tf0_set && !wr_ctrl
    |=> !timer_control_flags_reg.timer0_overflow_flag) else $error("ack did not clear flag");
  edge_flag_a: assert property (timer_control_flags_reg.ext_irq0_trigger_type && pin_fall[0]
    |=> timer_control_flags_reg.ext_irq0_edge_flag ##0 irq_req[2]) else $error("edge flag missed");
  gate_stop_a: assert property (timer_mode_register_reg.gate0 && !pin_lvl[0] && !wr_tl0
    |=> $stable(tl0)) else $error("gated timer counted");
  reload_c: cover property (mode1 == dtm_pkg::DTM_MODE_8_RELOAD && tl1_load);
  split_c:  cover property (split0 && th0_wrap ##1 timer_control_flags_reg.timer1_overflow_flag);
  edge_c:   cover property (ie1_set ##1 irq_req[3]);
  irq_c:    cover property (!irq ##1 irq);

endmodule

// [tb/dual_timer_modes_and_flags_bench.sv]
// bench of the dual timer block: register rows, then hand-written timer and irq cases
// assumes dtm_top and dtm_pkg; bench drives every port itself
`timescale 1ns/1ps
module dual_timer_modes_and_flags_bench;
  typedef struct packed {
    logic [11:0] addr;
    logic        do_wr;
    logic [7:0]  wdata;
    logic [7:0]  exp;
  } dtm_row_t;

  // ********
  // signals
  // ********
  logic                  sys_clk;
  logic                  rstn;
  dtm_pkg::dtm_bus_req_t bus_req;
  logic [7:0]            rd_data;
  logic                  ext_irq0_pin;
  logic                  ext_irq1_pin;
  logic                  t0_count_pin;
  logic                  t1_count_pin;
  logic [3:0]            irq_ack;
  logic [3:0]            irq_req;
  logic                  irq;
  logic                  t1_baud_tick;
  logic                  t0_toggle_out;
  logic                  t1_toggle_out;
  int                    errors;
  int                    samples_checked;
  int                    n;
  logic [7:0]            v;
  logic                  tog;
  logic [7:0]            rl [3] = '{8'hf0, 8'hfc, 8'hfe};
  int                    nd [3] = '{4, 16, 64};
  dtm_row_t              rows [11] = '{
    '{12'h410, 1'b0, 8'h00, 8'h00}, '{12'h45c, 1'b0, 8'h00, 8'h00},
    '{12'h420, 1'b0, 8'h00, 8'h00}, '{12'h45c, 1'b1, 8'h33, 8'h33},
    '{12'h411, 1'b1, 8'hfa, 8'hfa}, '{12'h412, 1'b1, 8'h02, 8'h02},
    '{12'h421, 1'b1, 8'h0a, 8'h0a}, '{12'h454, 1'b1, 8'h3c, 8'h3c},
    '{12'h457, 1'b1, 8'hc3, 8'hc3}, '{12'h410, 1'b1, 8'h05, 8'h05},
    '{12'h4ff, 1'b1, 8'h55, 8'h00}};

  dtm_top dut_u (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .bus_req       (bus_req),
    .rd_data       (rd_data),
    .ext_irq0_pin  (ext_irq0_pin),
    .ext_irq1_pin  (ext_irq1_pin),
    .t0_count_pin  (t0_count_pin),
    .t1_count_pin  (t1_count_pin),
    .irq_ack       (irq_ack),
    .irq_req       (irq_req),
    .irq           (irq),
    .t1_baud_tick  (t1_baud_tick),
    .t0_toggle_out (t0_toggle_out),
    .t1_toggle_out (t1_toggle_out)
  );

  // ********
  // tasks
  // ********
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  // counts edges until a request stands; running past the limit is a mismatch
  task automatic wait_req(input int b, input int lim, inout int cnt);
    while (irq_req[b] !== 1'b1 && cnt < lim)
    begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
    if (cnt >= lim)
      chk(8'h00, 8'h01);
  endtask

  task automatic ack(input int b);
    @(posedge sys_clk);
    irq_ack <= 4'h1 << b;
    @(posedge sys_clk);
    irq_ack <= 4'h0;
    #1;
  endtask

  task automatic start2(input int t, input int p, input logic [7:0] r);
    wr(12'h410, 8'h00);
    wr(12'h412, 8'(p));
    wr(12'h45c, t ? 8'h20 : 8'h02);
    wr(12'h451 + 12'(2 * t), 8'h77);
    wr(12'h454 + 12'(2 * t), r);
    wr(12'h450 + 12'(2 * t), 8'hff);
    wr(12'h410, t ? 8'h40 : 8'h10);
  endtask

  task automatic falls(input int k);
    repeat (k)
    begin
      repeat (4) @(posedge sys_clk);
      t0_count_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      t0_count_pin <= 1'b1;
    end
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic give_verdict();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ********
  // sequence
  // ********
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (30000) @(posedge sys_clk);
    errors++;
    give_verdict();
  end

  initial
  begin
    errors = 0;
    samples_checked = 0;
    rstn = 1'b0;
    bus_req = '0;
    irq_ack = 4'h0;
    {ext_irq1_pin, ext_irq0_pin, t1_count_pin, t0_count_pin} = 4'hf;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].do_wr)
        wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].exp);
    end
    wr(12'h411, 8'h00);
    wr(12'h421, 8'h00);
    // reload period for both timers and every prescaler
    for (int t = 0; t < 2; t++)
      for (int p = 0; p < 3; p++)
      begin
        start2(t, p, rl[p]);
        n = 0;
        wait_req(t, 200, n);
        ack(t);
        n = 2;
        wait_req(t, 200, n);
        chk(8'(n), 8'(nd[p] * (256 - rl[p])));
        wr(12'h410, 8'h00);
        rd(12'h410, 8'h00);
        rd(12'h451 + 12'(2 * t), 8'h77);
      end
    chk({7'h0, irq}, 8'h00);
    wr(12'h421, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wr(12'h420, 8'h01);
    chk({7'h0, irq}, 8'h00);
    rd(12'h420, 8'h02);
    wr(12'h420, 8'h02);
    wr(12'h421, 8'h00);
    // toggle enable keeps the overflow flag clear
    for (int t = 0; t < 2; t++)
    begin
      wr(12'h411, t ? 8'h04 : 8'h01);
      start2(t, 0, 8'hfc);
      repeat (40) @(posedge sys_clk);
      #1;
      tog = t ? t1_toggle_out : t0_toggle_out;
      repeat (16) @(posedge sys_clk);
      #1;
      chk({7'h0, t ? t1_toggle_out : t0_toggle_out}, {7'h0, ~tog});
      rd(12'h410, t ? 8'h40 : 8'h10);
      wr(12'h410, 8'h00);
      wr(12'h411, 8'h00);
    end
    // split mode: high byte of timer 0 on timer 1 run and flag
    wr(12'h412, 8'h00);
    wr(12'h45c, 8'h33);
    wr(12'h450, 8'h20);
    wr(12'h451, 8'hf0);
    wr(12'h452, 8'h12);
    wr(12'h453, 8'h34);
    wr(12'h410, 8'h40);
    n = 0;
    wait_req(1, 120, n);
    rd(12'h410, 8'hc0);
    rd(12'h450, 8'h20);
    rd(12'h452, 8'h12);
    rd(12'h453, 8'h34);
    wr(12'h456, 8'hfc);
    wr(12'h452, 8'hfc);
    wr(12'h45c, 8'h23);
    repeat (40) @(posedge sys_clk);
    n = 0;
    repeat (64)
    begin
      @(posedge sys_clk);
      #1;
      n += int'(t1_baud_tick);
    end
    chk(8'(n), 8'h04);
    // gated pin counter, 16-bit carry without reload
    wr(12'h410, 8'h00);
    wr(12'h45c, 8'h0d);
    wr(12'h450, 8'hfe);
    wr(12'h451, 8'h12);
    ext_irq0_pin <= 1'b0;
    wr(12'h410, 8'h10);
    falls(2);
    chk({7'h0, irq_req[2]}, 8'h01);
    rd(12'h450, 8'hfe);
    ext_irq0_pin <= 1'b1;
    falls(3);
    rd(12'h450, 8'h01);
    rd(12'h451, 8'h13);
    // falling-edge flags, cleared on acknowledge
    for (int i = 0; i < 2; i++)
    begin
      wr(12'h410, i ? 8'h04 : 8'h01);
      {ext_irq1_pin, ext_irq0_pin} <= i ? 2'b01 : 2'b10;
      repeat (6) @(posedge sys_clk);
      rd(12'h410, i ? 8'h0c : 8'h03);
      chk({7'h0, irq_req[2 + i]}, 8'h01);
      ack(2 + i);
      rd(12'h410, i ? 8'h04 : 8'h01);
      {ext_irq1_pin, ext_irq0_pin} <= 2'b11;
    end
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(12'h45c, 8'h00);
    rd(12'h410, 8'h00);
    rd(12'h452, 8'h00);
    give_verdict();
  end
endmodule
